//--- hw/sacs_pkg.sv
// shared constants for the serial converter sequencer and its host
package sacs_pkg;
   localparam int ADDR_W = 4;
   localparam int RES_W = 10;
   localparam int SYNC_W = 3;
   localparam int CNT_W = 5;
   localparam int CONV_W = 12;

   // edge counts within one transfer
   localparam logic [2:0] ADDR_EDGES = 3'h4;
   localparam logic [4:0] SAMPLE_FALL = 5'h04;
   localparam logic [4:0] HOLD_FALL = 5'h0a;
   localparam logic [4:0] LAST_FALL = 5'h10;
   localparam logic [4:0] MIN_CLKS = 5'h0a;
   localparam logic [4:0] MAX_CLKS = 5'h10;
   localparam logic [4:0] DATA_BITS = 5'h0a;

   // timing
   localparam int SYS_CLK_NS = 5;
   localparam int CONV_TIME_NS = 10000;
   localparam int CONV_CYC = (CONV_TIME_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int SLOW_GAP_NS = 9500;
   localparam int SLOW_GAP_CYC = SLOW_GAP_NS / SYS_CLK_NS;
   localparam logic [4:0] HALF_CYC = 5'h10;

   // multiplexer codes and fixed test results
   localparam logic [3:0] CH_LAST_ANALOG = 4'ha;
   localparam logic [3:0] CH_HALF = 4'hb;
   localparam logic [3:0] CH_LOW = 4'hc;
   localparam logic [3:0] CH_HIGH = 4'hd;
   localparam logic [9:0] CODE_HALF = 10'h200;
   localparam logic [9:0] CODE_LOW = 10'h000;
   localparam logic [9:0] CODE_HIGH = 10'h3ff;

   // values after reset
   localparam logic [9:0] RESULT_RST = 10'h000;
   localparam logic EOC_RST = 1'b1;
   localparam logic CS_N_RST = 1'b1;
endpackage

//--- hw/sacs_link_if.sv
// four-wire serial link plus end-of-conversion between host and converter
`timescale 1ns/1ps
interface sacs_link_if;
   logic cs_n;
   logic io_clk;
   logic addr;
   logic dout;
   logic dout_oe;
   logic eoc;
   // level seen on the three-state data wire; floats high when undriven
   logic dout_wire;
   assign dout_wire = dout_oe ? dout : 1'b1;

   modport dev (
      input cs_n,
      input io_clk,
      input addr,
      output dout,
      output dout_oe,
      output eoc
   );
   modport host (
      output cs_n,
      output io_clk,
      output addr,
      input dout_wire,
      input eoc
   );
endinterface

//--- hw/sacs_dev.sv
// converter end: serial address/result shifter and conversion sequencer
//
// Contract
// - address in MSB first on rises 1-4
// - track from fall 4, hold at fall 10
// - ten result bits, nine on later falls
// - conversion starts only at tenth fall
// - chip select high: ignore inputs, output off
// - chip select low: enable inputs, drive output
// - host gives 10 to 16 clocks
// - eoc low at fall 10, high when done
// - output forced low at tenth fall
// - MSB timing per mode
// - host modes 1, 3, 5 toggle select
// - host modes 2, 4, 6 hold select
// - fast when transfer ends before conversion
// - select rise floats output, stops inputs
// - previous result out while address in
// - slow mode: eleventh rise within 9.5 us
// - modes 2, 4: eoc rise presents MSB
// - address codes select inputs and references
`timescale 1ns/1ps
module sacs_dev #(
   parameter int CONV_CYCLES = sacs_pkg::CONV_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   sacs_link_if.dev link,
   input wire logic [9:0] ana_code_i,
   output logic [3:0] ana_sel_o,
   output logic ana_track_o,
   output logic [9:0] result_o,
   output logic busy_o
);

   typedef struct packed {
      logic [2:0] cs_s;
      logic [2:0] clk_s;
      logic [2:0] adr_s;
      logic cs_f;
      logic clk_f;
      logic adr_f;
      logic [2:0] rise_cnt;
      logic [4:0] fall_cnt;
      logic [3:0] adr_sh;
      logic [3:0] mux_sel;
      logic track;
      logic [9:0] held;
      logic busy;
      logic [11:0] conv_cnt;
      logic [9:0] result;
      logic [9:0] sh;
      logic dout;
      logic oe;
      logic eoc;
   } sacs_dev_st_t;

   sacs_dev_st_t st;
   sacs_dev_st_t next_st;

   logic cs_fall;
   logic cs_rise;
   logic clk_rise;
   logic clk_fall;
   logic [4:0] fall_inc;
   logic conv_done;

   // the value that a code selects, captured at the hold edge
   function automatic logic [9:0] sacs_pick(input logic [3:0] sel,
                                            input logic [9:0] code);
      logic [9:0] v;
      v = sacs_pkg::CODE_HALF;
      if (sel <= sacs_pkg::CH_LAST_ANALOG) begin
         v = code;
      end else if (sel == sacs_pkg::CH_HALF) begin
         v = sacs_pkg::CODE_HALF;
      end else if (sel == sacs_pkg::CH_LOW) begin
         v = sacs_pkg::CODE_LOW;
      end else if (sel == sacs_pkg::CH_HIGH) begin
         v = sacs_pkg::CODE_HIGH;
      end else begin
         v = sacs_pkg::CODE_HALF;
      end
      return v;
   endfunction

   always_comb begin
      next_st = st;
      cs_fall = 1'b0;
      cs_rise = 1'b0;
      clk_rise = 1'b0;
      clk_fall = 1'b0;
      fall_inc = st.fall_cnt;
      conv_done = 1'b0;

      // three-stage pin capture; a change counts once stages 2 and 3 agree
      next_st.cs_s = {st.cs_s[1:0], link.cs_n};
      next_st.clk_s = {st.clk_s[1:0], link.io_clk};
      next_st.adr_s = {st.adr_s[1:0], link.addr};
      if (st.cs_s[1] == st.cs_s[2]) begin
         next_st.cs_f = st.cs_s[2];
      end
      if (st.clk_s[1] == st.clk_s[2]) begin
         next_st.clk_f = st.clk_s[2];
      end
      if (st.adr_s[1] == st.adr_s[2]) begin
         next_st.adr_f = st.adr_s[2];
      end
      cs_fall = st.cs_f & ~next_st.cs_f;
      cs_rise = ~st.cs_f & next_st.cs_f;
      // clock edges only count while selected
      clk_rise = ~st.clk_f & next_st.clk_f & ~st.cs_f;
      clk_fall = st.clk_f & ~next_st.clk_f & ~st.cs_f;

      // conversion runs on the system clock, independent of the select
      if (st.busy) begin
         if (st.conv_cnt <= 12'h001) begin
            conv_done = 1'b1;
            next_st.busy = 1'b0;
            next_st.eoc = 1'b1;
            next_st.result = st.held;
         end else begin
            next_st.conv_cnt = st.conv_cnt - 12'h001;
         end
      end

      // fast continuous modes: eoc rise starts the next sequence
      if (conv_done && !st.cs_f &&
          (st.fall_cnt == sacs_pkg::HOLD_FALL ||
           st.fall_cnt == sacs_pkg::LAST_FALL)) begin
         next_st.rise_cnt = '0;
         next_st.fall_cnt = '0;
         next_st.sh = st.held;
         next_st.dout = st.held[9];
      end

      if (cs_fall) begin
         // a new select resets the counters and shows the last result
         next_st.rise_cnt = '0;
         next_st.fall_cnt = '0;
         next_st.oe = 1'b1;
         next_st.sh = next_st.result;
         next_st.dout = next_st.result[9];
      end else if (cs_rise) begin
         // the conversion in flight carries on after deselect
         next_st.oe = 1'b0;
         next_st.track = 1'b0;
      end

      if (clk_rise && st.rise_cnt < sacs_pkg::ADDR_EDGES) begin
         next_st.rise_cnt = st.rise_cnt + 3'h1;
         next_st.adr_sh = {st.adr_sh[2:0], st.adr_f};
         if (st.rise_cnt == sacs_pkg::ADDR_EDGES - 3'h1) begin
            next_st.mux_sel = {st.adr_sh[2:0], st.adr_f};
         end
      end

      if (clk_fall) begin
         if (st.fall_cnt < sacs_pkg::LAST_FALL) begin
            fall_inc = st.fall_cnt + 5'h01;
         end
         next_st.fall_cnt = fall_inc;
         if (fall_inc < sacs_pkg::HOLD_FALL) begin
            next_st.sh = {st.sh[8:0], 1'b0};
            next_st.dout = st.sh[8];
         end
         if (fall_inc == sacs_pkg::SAMPLE_FALL) begin
            next_st.track = 1'b1;
         end
         if (fall_inc == sacs_pkg::HOLD_FALL) begin
            next_st.track = 1'b0;
            next_st.held = sacs_pick(st.mux_sel, ana_code_i);
            next_st.busy = 1'b1;
            next_st.conv_cnt = CONV_CYCLES[11:0];
            next_st.eoc = 1'b0;
            next_st.dout = 1'b0;
         end
         // slow continuous mode: sixteenth fall starts the next sequence
         if (fall_inc == sacs_pkg::LAST_FALL &&
             st.fall_cnt != sacs_pkg::LAST_FALL && !next_st.busy) begin
            next_st.rise_cnt = '0;
            next_st.fall_cnt = '0;
            next_st.sh = next_st.result;
            next_st.dout = next_st.result[9];
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         st <= '0;
         st.cs_s <= 3'h7;
         st.cs_f <= sacs_pkg::CS_N_RST;
         st.result <= sacs_pkg::RESULT_RST;
         st.eoc <= sacs_pkg::EOC_RST;
      end else begin
         st <= next_st;
      end
   end

   assign link.dout = st.dout;
   assign link.dout_oe = st.oe;
   assign link.eoc = st.eoc;
   assign ana_sel_o = st.mux_sel;
   assign ana_track_o = st.track;
   assign result_o = st.result;
   assign busy_o = st.busy;

endmodule // sacs_dev

//--- hw/sacs_host.sv
// host end: serial port master that clocks one transfer per request
`timescale 1ns/1ps
module sacs_host (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   sacs_link_if.host link,
   input wire logic start_i,
   input wire logic [3:0] chan_i,
   input wire logic [4:0] nclk_i,
   input wire logic keep_cs_i,
   output logic ready_o,
   output logic [9:0] data_o,
   output logic data_valid_o,
   output logic eoc_o
);

   typedef enum logic [2:0] {
      H_IDLE = 3'b000,
      H_WAIT = 3'b001,
      H_LOW = 3'b011,
      H_HIGH = 3'b010,
      H_END = 3'b110
   } sacs_hstate_t;

   typedef struct packed {
      sacs_hstate_t state;
      logic [2:0] do_s;
      logic [2:0] eoc_s;
      logic do_f;
      logic eoc_f;
      logic cs_n;
      logic io_clk;
      logic [3:0] chan_sh;
      logic [4:0] nclk;
      logic keep;
      logic [4:0] timer;
      logic [4:0] edges;
      logic [9:0] dsh;
      logic [9:0] data;
      logic valid;
   } sacs_host_st_t;

   sacs_host_st_t st;
   sacs_host_st_t next_st;

   always_comb begin
      next_st = st;
      next_st.valid = 1'b0;
      next_st.do_s = {st.do_s[1:0], link.dout_wire};
      next_st.eoc_s = {st.eoc_s[1:0], link.eoc};
      if (st.do_s[1] == st.do_s[2]) begin
         next_st.do_f = st.do_s[2];
      end
      if (st.eoc_s[1] == st.eoc_s[2]) begin
         next_st.eoc_f = st.eoc_s[2];
      end
      if (st.timer != 5'h00) begin
         next_st.timer = st.timer - 5'h01;
      end

      case (st.state)
         H_IDLE: begin
            if (start_i) begin
               next_st.chan_sh = chan_i;
               next_st.keep = keep_cs_i;
               // never fewer than ten, never more than sixteen
               if (nclk_i < sacs_pkg::MIN_CLKS) begin
                  next_st.nclk = sacs_pkg::MIN_CLKS;
               end else if (nclk_i > sacs_pkg::MAX_CLKS) begin
                  next_st.nclk = sacs_pkg::MAX_CLKS;
               end else begin
                  next_st.nclk = nclk_i;
               end
               // held select allows only 10 or exactly 16 clocks
               if (keep_cs_i && nclk_i != sacs_pkg::MIN_CLKS) begin
                  next_st.nclk = sacs_pkg::MAX_CLKS;
               end
               next_st.edges = '0;
               next_st.timer = sacs_pkg::HALF_CYC;
               next_st.state = H_WAIT;
            end
         end
         H_WAIT: begin
            // wait for the last conversion so the MSB is settled
            if (!st.eoc_f) begin
               next_st.timer = sacs_pkg::HALF_CYC;
            end else if (st.timer == 5'h00) begin
               next_st.cs_n = 1'b0;
               next_st.timer = sacs_pkg::HALF_CYC;
               next_st.state = H_LOW;
            end
         end
         H_LOW: begin
            if (st.timer == 5'h00) begin
               if (st.edges < sacs_pkg::DATA_BITS) begin
                  next_st.dsh = {st.dsh[8:0], st.do_f};
               end
               next_st.io_clk = 1'b1;
               next_st.edges = st.edges + 5'h01;
               next_st.timer = sacs_pkg::HALF_CYC;
               next_st.state = H_HIGH;
            end
         end
         H_HIGH: begin
            // short half period keeps the eleventh rise inside the gap
            if (st.timer == 5'h00) begin
               next_st.io_clk = 1'b0;
               next_st.chan_sh = {st.chan_sh[2:0], 1'b0};
               next_st.timer = sacs_pkg::HALF_CYC;
               next_st.state = (st.edges == st.nclk) ? H_END : H_LOW;
            end
         end
         H_END: begin
            if (st.timer == 5'h00) begin
               next_st.cs_n = ~st.keep;
               next_st.data = st.dsh;
               next_st.valid = 1'b1;
               next_st.state = H_IDLE;
            end
         end
         default: begin
            next_st.state = H_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         st <= '0;
         st.state <= H_IDLE;
         st.cs_n <= sacs_pkg::CS_N_RST;
      end else begin
         st <= next_st;
      end
   end

   assign link.cs_n = st.cs_n;
   assign link.io_clk = st.io_clk;
   assign link.addr = st.chan_sh[3];
   assign ready_o = (st.state == H_IDLE);
   assign data_o = st.data;
   assign data_valid_o = st.valid;
   assign eoc_o = st.eoc_f;

endmodule // sacs_host

//--- testbench/sacs_link_asserts.sv
// concurrent checks on the serial link between host and converter ends
`timescale 1ns/1ps
module sacs_link_asserts #(
   parameter int CONV_CYCLES = sacs_pkg::CONV_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic cs_n,
   input wire logic io_clk,
   input wire logic addr,
   input wire logic dout,
   input wire logic dout_oe,
   input wire logic eoc,
   input wire logic dout_wire
);
   logic io_q;
   logic cs_q;
   logic eoc_q;
   logic [4:0] n_fall;
   logic [7:0] since_ev;
   logic [15:0] low_cnt;
   logic fall_ev;
   // falls counted on the raw wire; the device sees them a few cycles late
   assign fall_ev = io_q && !io_clk && !cs_n;
   always_ff @(posedge clk_sys_i) begin
      if (!reset_n_i) begin
         io_q <= 1'b0;
         cs_q <= 1'b1;
         eoc_q <= 1'b1;
         n_fall <= 5'h00;
         since_ev <= 8'h00;
         low_cnt <= 16'h0000;
      end else begin
         io_q <= io_clk;
         cs_q <= cs_n;
         eoc_q <= eoc;
         low_cnt <= eoc ? 16'h0000 : low_cnt + 16'h0001;
         if (cs_q && !cs_n) begin
            n_fall <= 5'h00;
         end else if (fall_ev) begin
            n_fall <= (n_fall == 5'h10) ? 5'h01 : n_fall + 5'h01;
         end else if (eoc && !eoc_q && !cs_n
                      && (n_fall == 5'h0a || n_fall == 5'h10)) begin
            n_fall <= 5'h00;
         end
         if (fall_ev || cs_n != cs_q) begin
            since_ev <= 8'h00;
         end else if (since_ev != 8'hff) begin
            since_ev <= since_ev + 8'h01;
         end
      end
   end

   a_float_when_idle: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) cs_n [*8] |-> !dout_oe && dout_wire)
      else $error("data driven while deselected");
   a_addr_steady: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) $rose(io_clk) |-> $stable(addr))
      else $error("address moved at clock rise");
   a_drive_on_select: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) $fell(cs_n) |-> ##[1:6] dout_oe)
      else $error("data not driven after select");
   a_stay_driven: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) !cs_n [*8] |-> dout_oe)
      else $error("data released while selected");
   a_float_on_release: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) $rose(cs_n) |-> ##[1:6] !dout_oe)
      else $error("data not released after deselect");
   a_eoc_tenth_fall: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) fall_ev && n_fall == 5'h09 |-> ##[2:8] !eoc)
      else $error("conversion not started at tenth fall");
   a_no_early_conv: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) $fell(eoc) |-> n_fall == 5'h0a)
      else $error("conversion started at wrong fall");
   a_zero_after_tenth: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i)
      fall_ev && n_fall == 5'h09 |-> ##8 (dout_oe && !dout))
      else $error("data not forced low after tenth fall");
   a_conv_duration: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) $rose(eoc) |->
      low_cnt >= CONV_CYCLES - 1 && low_cnt <= CONV_CYCLES + 1)
      else $error("conversion time wrong");
   a_shift_on_edge: assert property (@(posedge clk_sys_i)
      disable iff (!reset_n_i) $changed(dout) && dout_oe && $past(dout_oe)
      |-> $rose(eoc) || since_ev <= 8'h06)
      else $error("data changed without a clock edge");
endmodule // sacs_link_asserts

//--- testbench/serial_adc_conversion_sequencer_tb_top.sv
// self-checking bench: host and converter ends joined over the serial link
`timescale 1ns/1ps
module serial_adc_conversion_sequencer_tb_top;
   localparam int CONV = 100;
   logic clk_sys_i;
   logic reset_n_i;
   logic start_i;
   logic [3:0] chan_i;
   logic [4:0] nclk_i;
   logic keep_cs_i;
   logic [9:0] ana_code_i;
   logic ready_o;
   logic [9:0] data_o;
   logic data_valid_o;
   logic eoc_o;
   logic [3:0] ana_sel_o;
   logic ana_track_o;
   logic [9:0] result_o;
   logic busy_o;
   int n_errors;
   int checks;
   logic [9:0] prev;

   sacs_link_if lnk();
   sacs_dev #(.CONV_CYCLES(CONV)) sacs_dev_i (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .link(lnk), .ana_code_i(ana_code_i),
      .ana_sel_o(ana_sel_o), .ana_track_o(ana_track_o),
      .result_o(result_o), .busy_o(busy_o));
   sacs_host sacs_host_i (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .link(lnk), .start_i(start_i), .chan_i(chan_i), .nclk_i(nclk_i),
      .keep_cs_i(keep_cs_i), .ready_o(ready_o), .data_o(data_o),
      .data_valid_o(data_valid_o), .eoc_o(eoc_o));
   sacs_link_asserts #(.CONV_CYCLES(CONV)) sacs_link_asserts_i (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cs_n(lnk.cs_n),
      .io_clk(lnk.io_clk), .addr(lnk.addr), .dout(lnk.dout),
      .dout_oe(lnk.dout_oe), .eoc(lnk.eoc), .dout_wire(lnk.dout_wire));

   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk10(input logic [9:0] got, input logic [9:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // one transfer: reads back the previous result, converts channel ch
   task automatic xfer(input logic [3:0] ch, input logic [4:0] nc,
                       input logic keep);
      int k;
      logic [9:0] exp;
      k = 0;
      while (ready_o !== 1'b1 && k < 20000) begin
         @(posedge clk_sys_i);
         #1;
         k++;
      end
      start_i = 1'b1;
      chan_i = ch;
      nclk_i = nc;
      keep_cs_i = keep;
      ana_code_i = {ch, ~ch, 2'h2};
      @(posedge clk_sys_i);
      #1;
      start_i = 1'b0;
      k = 0;
      while (data_valid_o !== 1'b1 && k < 20000) begin
         @(posedge clk_sys_i);
         #1;
         k++;
      end
      chk1(data_valid_o, 1'b1);
      chk10(data_o, prev);
      chk4(ana_sel_o, ch);
      // a ten-clock transfer ends before its conversion does
      if (nc == sacs_pkg::MIN_CLKS) begin
         chk1(eoc_o, 1'b0);
      end
      case (ch)
         4'hb, 4'he, 4'hf: exp = sacs_pkg::CODE_HALF;
         4'hc: exp = sacs_pkg::CODE_LOW;
         4'hd: exp = sacs_pkg::CODE_HIGH;
         default: exp = {ch, ~ch, 2'h2};
      endcase
      k = 0;
      while (busy_o !== 1'b0 && k < 5000) begin
         @(posedge clk_sys_i);
         #1;
         k++;
      end
      chk10(result_o, exp);
      // the host sees eoc through its three-stage capture
      repeat (5) @(posedge clk_sys_i);
      #1;
      chk1(eoc_o, 1'b1);
      chk1(ana_track_o, 1'b0);
      prev = exp;
   endtask

   initial begin
      n_errors = 0;
      checks = 0;
      prev = sacs_pkg::RESULT_RST;
      reset_n_i = 1'b0;
      start_i = 1'b0;
      chan_i = 4'h0;
      nclk_i = 5'h0a;
      keep_cs_i = 1'b0;
      ana_code_i = 10'h000;
      repeat (5) @(posedge clk_sys_i);
      #1;
      reset_n_i = 1'b1;
      repeat (4) @(posedge clk_sys_i);
      #1;
      chk1(lnk.dout_oe, 1'b0);
      chk1(lnk.dout_wire, 1'b1);
      chk1(lnk.eoc, sacs_pkg::EOC_RST);
      // every code, clock counts 10 to 16, select kept low on pairs
      for (int i = 0; i < 16; i++) begin
         xfer(i[3:0], 5'h0a + 5'(i % 7), i[1]);
      end
      xfer(4'h3, 5'h10, 1'b0);
      xfer(4'ha, 5'h0a, 1'b0);
      end_of_test();
   end

   // bound well above eighteen transfers of at most about 600 cycles each
   initial begin
      repeat (80000) @(posedge clk_sys_i);
      n_errors++;
      end_of_test();
   end
endmodule // serial_adc_conversion_sequencer_tb_top
